// ==== logic/incr_unit_params.svh ====
`ifndef INCR_UNIT_PARAMS_SVH
`define INCR_UNIT_PARAMS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define HALF_W 18
`define WORD_W 60
`define EXT_W 42
`define REG_CNT 8

// ==========================================================================
// Opcode groups and designator encodings
// ==========================================================================
`define OP_FIRST 6'h2c
`define GRP_SET_ADDR 3'h5
`define GRP_SET_INCR 3'h6
`define GRP_SET_OPND 3'h7
`define SEL_IMM_LAST 3'h2
`define SEL_X_LAST 3'h3
`define SEL_A_SUB 3'h5
`define SEL_B_SUB 3'h7
`define DES_NONE 3'h0
`define DES_WRITE_MIN 3'h6

// ==========================================================================
// Reset values
// ==========================================================================
`define HALF_RST 18'h00000
`define WORD_RST 60'h000000000000000

`endif

// ==== logic/incr_unit_pkg.sv ====
package incr_unit_pkg;

  typedef logic [17:0] half_t;
  typedef logic [59:0] word_t;
  typedef logic [2:0] reg_idx_t;
  typedef logic [5:0] opcode_t;

  typedef enum logic [1:0] {
    SRC_ADDR,
    SRC_INCR,
    SRC_OPND
  } src_t;

  typedef enum logic [1:0] {
    DST_ADDR,
    DST_INCR,
    DST_OPND
  } dest_t;

endpackage

// ==== logic/oc_add_if.sv ====
interface oc_add_if;
  import incr_unit_pkg::*;

  half_t op_j;
  half_t op_k;
  logic sub;
  half_t sum;

  modport user (output op_j, output op_k, output sub, input sum);
  modport adder (input op_j, input op_k, input sub, output sum);
endinterface

// ==== logic/ones_comp_adder.sv ====
`include "incr_unit_params.svh"

module ones_comp_adder (
  oc_add_if.adder bus
);
  import incr_unit_pkg::*;

  // ==========================================================================
  // Ones-complement add with end-around carry
  // ==========================================================================
  wire half_t k_term;
  wire logic [`HALF_W:0] raw_sum;

  assign k_term = bus.sub ? ~bus.op_k : bus.op_k;
  assign raw_sum = {1'b0, bus.op_j} + {1'b0, k_term};
  // The carry out is fed back into bit zero; this add cannot carry again.
  assign bus.sum = raw_sum[`HALF_W-1:0] + {{(`HALF_W-1){1'b0}}, raw_sum[`HALF_W]};

endmodule

// ==== logic/incr_set_unit.sv ====
`include "incr_unit_params.svh"

module incr_set_unit (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic instr_valid_i,
  input wire incr_unit_pkg::opcode_t opcode_i,
  input wire incr_unit_pkg::reg_idx_t dest_sel_i,
  input wire incr_unit_pkg::reg_idx_t j_sel_i,
  input wire incr_unit_pkg::reg_idx_t k_sel_i,
  input wire incr_unit_pkg::half_t imm_i,
  input wire logic mem_rvalid_i,
  input wire incr_unit_pkg::word_t mem_rdata_i,
  output logic retire_o,
  output incr_unit_pkg::dest_t retire_dest_o,
  output incr_unit_pkg::reg_idx_t retire_idx_o,
  output incr_unit_pkg::word_t result_o,
  output logic mem_req_o,
  output logic mem_write_o,
  output incr_unit_pkg::half_t mem_addr_o,
  output incr_unit_pkg::word_t mem_wdata_o
);
  import incr_unit_pkg::*;

  // ==========================================================================
  // Register files
  // ==========================================================================
  half_t addr_rf_ff [`REG_CNT];
  half_t incr_rf_ff [`REG_CNT];
  word_t opnd_rf_ff [`REG_CNT];
  reg_idx_t rd_dst_ff;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic [2:0] grp;
  wire logic [2:0] sel;
  wire logic legal;
  wire logic use_imm;
  wire logic do_sub;
  wire src_t j_src;
  wire dest_t dest;
  wire half_t j_val;
  wire half_t k_val;
  wire word_t opnd_i_val;
  wire word_t ext_sum;
  wire logic ref_start;
  wire logic ref_write;

  assign grp = opcode_i[5:3];
  assign sel = opcode_i[2:0];
  assign legal = instr_valid_i && (opcode_i >= `OP_FIRST);
  assign use_imm = (grp != `GRP_SET_ADDR) && (sel <= `SEL_IMM_LAST);
  assign do_sub = (sel == `SEL_A_SUB) || (sel == `SEL_B_SUB);
  assign j_src = (sel == 3'h0 || sel == 3'h4 || sel == 3'h5) ? SRC_ADDR :
                 (sel == 3'h1 || sel == 3'h6 || sel == 3'h7) ? SRC_INCR : SRC_OPND;
  assign dest = (grp == `GRP_SET_ADDR) ? DST_ADDR :
                (grp == `GRP_SET_INCR) ? DST_INCR : DST_OPND;
  assign j_val = (j_src == SRC_ADDR) ? addr_rf_ff[j_sel_i] :
                 (j_src == SRC_INCR) ? incr_rf_ff[j_sel_i] :
                 opnd_rf_ff[j_sel_i][`HALF_W-1:0];
  assign k_val = use_imm ? imm_i : incr_rf_ff[k_sel_i];
  assign opnd_i_val = opnd_rf_ff[dest_sel_i];

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  oc_add_if add_bus ();

  assign add_bus.op_j = j_val;
  assign add_bus.op_k = k_val;
  assign add_bus.sub = do_sub;

  ones_comp_adder u_adder (
    .bus(add_bus)
  );

  assign ext_sum = {{`EXT_W{add_bus.sum[`HALF_W-1]}}, add_bus.sum};
  assign ref_start = legal && (dest == DST_ADDR) && (dest_sel_i != `DES_NONE);
  assign ref_write = dest_sel_i >= `DES_WRITE_MIN;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int n = 0; n < `REG_CNT; n++) begin
        addr_rf_ff[n] <= `HALF_RST;
        incr_rf_ff[n] <= `HALF_RST;
      end
    end else if (legal && dest == DST_ADDR) begin
      addr_rf_ff[dest_sel_i] <= add_bus.sum;
    end else if (legal && dest == DST_INCR) begin
      incr_rf_ff[dest_sel_i] <= add_bus.sum;
    end
  end

  // An instruction result wins over a returning read aimed at the same register.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int n = 0; n < `REG_CNT; n++) begin
        opnd_rf_ff[n] <= `WORD_RST;
      end
    end else begin
      if (mem_rvalid_i) begin
        opnd_rf_ff[rd_dst_ff] <= mem_rdata_i;
      end
      if (legal && dest == DST_OPND) begin
        opnd_rf_ff[dest_sel_i] <= ext_sum;
      end
    end
  end

  // ==========================================================================
  // Retire report and main store reference
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      retire_o <= 1'b0;
      retire_dest_o <= DST_ADDR;
      retire_idx_o <= 3'h0;
      result_o <= `WORD_RST;
    end else begin
      retire_o <= legal;
      retire_dest_o <= dest;
      retire_idx_o <= dest_sel_i;
      result_o <= (dest == DST_OPND) ? ext_sum : {{`EXT_W{1'b0}}, add_bus.sum};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o <= `HALF_RST;
      mem_wdata_o <= `WORD_RST;
      rd_dst_ff <= 3'h0;
    end else begin
      mem_req_o <= ref_start;
      mem_write_o <= ref_start && ref_write;
      if (ref_start) begin
        mem_addr_o <= add_bus.sum;
        mem_wdata_o <= opnd_i_val;
      end
      if (ref_start && !ref_write) begin
        rd_dst_ff <= dest_sel_i;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  function automatic half_t oc_ref(input half_t a, input half_t b);
    logic [18:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[17:0] + {17'h0, t[18]};
  endfunction

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_addr_dest: assert property (
    legal && grp == `GRP_SET_ADDR |=>
      retire_o && retire_dest_o == DST_ADDR && retire_idx_o == $past(dest_sel_i))
    else $error("address set did not retire to the address register");
  a_incr_imm: assert property (
    legal && grp == `GRP_SET_INCR && sel <= `SEL_IMM_LAST |=>
      retire_dest_o == DST_INCR && result_o[17:0] == oc_ref($past(j_val), $past(imm_i)))
    else $error("increment immediate sum wrong");
  a_incr_reg: assert property (
    legal && grp == `GRP_SET_INCR && sel > `SEL_IMM_LAST |=>
      result_o[17:0] == ($past(do_sub) ?
        oc_ref($past(j_val), ~$past(incr_rf_ff[k_sel_i])) :
        oc_ref($past(j_val), $past(incr_rf_ff[k_sel_i]))))
    else $error("increment register result wrong");
  a_opnd_imm: assert property (
    legal && grp == `GRP_SET_OPND && sel <= `SEL_IMM_LAST |=>
      retire_dest_o == DST_OPND ##1
      opnd_rf_ff[$past(retire_idx_o)][17:0] == $past(result_o[17:0]))
    else $error("operand immediate result not stored");
  a_sub_order: assert property (
    legal && do_sub |=>
      result_o[17:0] == oc_ref($past(j_val), ~$past(k_val)))
    else $error("difference not j minus k");
  a_sign_ext: assert property (
    retire_o && retire_dest_o == DST_OPND |->
      result_o[59:18] == {42{result_o[17]}})
    else $error("operand result not sign extended");
  a_end_carry: assert property (
    legal && !do_sub && j_val == 18'h3ffff && k_val == 18'h00001 |=>
      result_o[17:0] == 18'h00001)
    else $error("end-around carry missing");
  a_no_ref: assert property (
    legal && grp == `GRP_SET_ADDR && dest_sel_i == `DES_NONE |=> !mem_req_o)
    else $error("reference made with zero designator");
  a_read_ref: assert property (
    legal && grp == `GRP_SET_ADDR && dest_sel_i != `DES_NONE &&
      dest_sel_i < `DES_WRITE_MIN |=>
      mem_req_o && !mem_write_o && mem_addr_o == result_o[17:0])
    else $error("read reference wrong");
  a_write_ref: assert property (
    legal && grp == `GRP_SET_ADDR && dest_sel_i >= `DES_WRITE_MIN |=>
      mem_req_o && mem_write_o && mem_wdata_o == $past(opnd_i_val))
    else $error("write reference wrong");
  a_read_land: assert property (
    mem_rvalid_i && !(legal && dest == DST_OPND && dest_sel_i == rd_dst_ff) |=>
      opnd_rf_ff[$past(rd_dst_ff)] == $past(mem_rdata_i))
    else $error("returned read word not stored");

  c_read_ref: cover property (mem_req_o && !mem_write_o ##[1:8] mem_rvalid_i);
  c_write_ref: cover property (mem_req_o && mem_write_o);
  c_neg_ext: cover property (retire_o && retire_dest_o == DST_OPND && result_o[17]);
  c_sub_wrap: cover property (legal && do_sub && j_val < k_val);

endmodule

// ==== tb/main_store_model.sv ====
module main_store_model (
  input wire logic ref_clk_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic mem_write_i,
  input wire incr_unit_pkg::half_t mem_addr_i,
  output logic mem_rvalid_o,
  output incr_unit_pkg::word_t mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import incr_unit_pkg::*;
  int cnt = 0;
  half_t addr_q = 18'h00000;
  wire logic fire;
  assign fire = (cnt == 1) && !(mem_req_i && !mem_write_i);
  initial begin
    mem_rvalid_o = 1'b0;
    mem_rdata_o = 60'h0;
  end
  // Read data is a pattern of the address; between returns the data lines churn.
  always @(posedge ref_clk_i) begin
    mem_rvalid_o <= fire;
    mem_rdata_o <= fire ? {addr_q, ~addr_q, addr_q, 6'h15} : ~mem_rdata_o;
    if (mem_req_i && !mem_write_i) begin
      addr_q <= mem_addr_i;
      cnt <= slow_i ? 6 : 1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== tb/test_increment_unit_set_ops.sv ====
module test_increment_unit_set_ops;
  timeunit 1ns;
  timeprecision 1ps;
  import incr_unit_pkg::*;
  logic ref_clk_i, srst_i, instr_valid_i, mem_rvalid_i, slow, retire_o, mem_req_o, mem_write_o;
  opcode_t opcode_i;
  reg_idx_t dest_sel_i, j_sel_i, k_sel_i, retire_idx_o;
  half_t imm_i, mem_addr_o;
  word_t mem_rdata_i, result_o, mem_wdata_o;
  dest_t retire_dest_o;
  half_t a_r[8], b_r[8];
  word_t x_r[8];
  int n_mismatch = 0, n_checks = 0, cycles = 0;
  incr_set_unit u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .dest_sel_i(dest_sel_i), .j_sel_i(j_sel_i), .k_sel_i(k_sel_i),
    .imm_i(imm_i), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .retire_o(retire_o), .retire_dest_o(retire_dest_o), .retire_idx_o(retire_idx_o),
    .result_o(result_o), .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o));
  main_store_model u_mem (.ref_clk_i(ref_clk_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i));
  // ==========================================================================
  // Checking and instruction issue
  // ==========================================================================
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input word_t exp, input word_t got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      n_mismatch++;
    end
  endtask
  // Issues one instruction at a falling edge and judges the retirement one cycle later.
  task automatic exec(input opcode_t op, input reg_idx_t i, j, k, input half_t imm);
    half_t a;
    half_t b;
    half_t r;
    logic [18:0] s;
    word_t res;
    case (op[2:0])
      3'h0, 3'h4, 3'h5: a = a_r[j];
      3'h2, 3'h3: a = x_r[j][17:0];
      default: a = b_r[j];
    endcase
    b = (op[2:0] <= 3'h2) ? imm : b_r[k];
    if (op[0] && op[2]) begin
      b = ~b;
    end
    s = {1'b0, a} + {1'b0, b};
    r = s[17:0] + {17'h0, s[18]};
    res = (op[5:3] == 3'h7) ? {{42{r[17]}}, r} : {42'h0, r};
    {opcode_i, dest_sel_i, j_sel_i, k_sel_i, imm_i} = {op, i, j, k, imm};
    instr_valid_i = 1'b1;
    @(negedge ref_clk_i);
    chk(60'h1, {59'h0, retire_o});
    chk({58'h0, 2'(op[5:3] - 3'h5)}, {58'h0, retire_dest_o});
    chk({57'h0, i}, {57'h0, retire_idx_o});
    chk(res, result_o);
    chk({59'h0, op[5:3] == 3'h5 && i != 3'h0}, {59'h0, mem_req_o});
    if (op[5:3] == 3'h5) begin
      a_r[i] = r;
      if (i != 3'h0) begin
        chk({42'h0, r}, {42'h0, mem_addr_o});
        chk({59'h0, i >= 3'h6}, {59'h0, mem_write_o});
      end
      if (i >= 3'h6) begin
        chk(x_r[i], mem_wdata_o);
      end
    end else if (op[5:3] == 3'h6) begin
      b_r[i] = r;
    end else begin
      x_r[i] = res;
    end
  endtask
  task automatic wait_read(input reg_idx_t i, input half_t ad);
    instr_valid_i = 1'b0;
    for (int n = 0; n < 20 && mem_rvalid_i !== 1'b1; n++) begin
      @(negedge ref_clk_i);
    end
    chk(60'h1, {59'h0, mem_rvalid_i});
    x_r[i] = {ad, ~ad, ad, 6'h15};
    @(negedge ref_clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_immediates();
    exec(6'h31, 3'h1, 3'h0, 3'h0, 18'h00005);
    exec(6'h30, 3'h2, 3'h0, 3'h0, 18'h3fffa);
    exec(6'h32, 3'h3, 3'h0, 3'h0, 18'h12345);
    exec(6'h30, 3'h4, 3'h0, 3'h0, 18'h3ffff);
    exec(6'h31, 3'h5, 3'h4, 3'h0, 18'h00001);
    exec(6'h38, 3'h1, 3'h0, 3'h0, 18'h20001);
    exec(6'h39, 3'h2, 3'h1, 3'h0, 18'h00010);
    exec(6'h3a, 3'h3, 3'h1, 3'h0, 18'h1ffff);
  endtask
  task automatic t_reg_ops();
    for (int n = 0; n < 5; n++) begin
      exec(6'(8'h33 + n), 3'h4, 3'h3, 3'h2, 18'h0);
    end
    for (int n = 0; n < 5; n++) begin
      exec(6'(8'h3b + n), 3'h5, 3'h1, 3'h2, 18'h0);
    end
  endtask
  task automatic t_addr_refs();
    exec(6'h2c, 3'h0, 3'h1, 3'h1, 18'h0);
    for (int n = 1; n < 6; n++) begin
      slow = n[0];
      exec(6'(8'h2c + n % 4), 3'(n), 3'(n - 1), 3'h2, 18'h0);
      wait_read(3'(n), a_r[n]);
    end
    exec(6'h3a, 3'h6, 3'h3, 3'h0, 18'h0);
    exec(6'h2d, 3'h6, 3'h2, 3'h1, 18'h0);
    exec(6'h2f, 3'h7, 3'h2, 3'h4, 18'h0);
  endtask
  // Refused words must leave A7 and X7 as they were; the two reads afterwards show it.
  task automatic t_refused();
    opcode_i = 6'h2b;
    @(negedge ref_clk_i);
    chk(60'h0, {58'h0, retire_o, mem_req_o});
    instr_valid_i = 1'b0;
    opcode_i = 6'h3f;
    @(negedge ref_clk_i);
    chk(60'h0, {58'h0, retire_o, mem_req_o});
    exec(6'h3c, 3'h5, 3'h7, 3'h0, 18'h0);
    exec(6'h3b, 3'h5, 3'h7, 3'h0, 18'h0);
  endtask
  // ==========================================================================
  // Clock, reset and sequence
  // ==========================================================================
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {srst_i, instr_valid_i, slow} = 3'b100;
    {opcode_i, dest_sel_i, j_sel_i, k_sel_i, imm_i} = '0;
    foreach (a_r[n]) {a_r[n], b_r[n], x_r[n]} = '0;
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
    @(negedge ref_clk_i);
    chk(60'h0, result_o);
    chk(60'h0, {58'h0, retire_o, mem_req_o});
    t_immediates();
    t_reg_ops();
    t_addr_refs();
    t_refused();
    stop_test();
  end
endmodule
